// >>> src/cmmd_decoder.sv
// Module decoder and stack line decoder gating for a core memory of up to four stacks.
module cmmd_decoder
	import cmmd_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic              phase5,
	input  wire logic              loader_protect_sel,
	input  wire cmmd_stacks_type   stack_count,
	input  wire cmmd_timing_type   line_timing_enable,
	input  wire logic [REG_AW-1:0] reg_addr,
	input  wire logic [REG_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [REG_DW-1:0]      reg_rdata,
	output logic [MOD_N-1:0]       module_select,
	output logic [CARD_N-1:0]      card_enable_n,
	output logic [PAGE_W-1:0]      stack_addr,
	output cmmd_lines_type         card_lines [CARD_N],
	output logic                   three_stack_present,
	output logic                   four_stack_present
);

	function automatic logic [7:0] oct_decode(input logic en, input logic [DIGIT_W-1:0] d);
		oct_decode = en ? (8'h01 << d) : 8'h00;
	endfunction

	cmmd_pins_type   pin_s1_reg;
	cmmd_pins_type   pin_s2_reg;
	cmmd_pins_type   pin;
	logic [DIGIT_W-1:0] dec_in;
	logic [MOD_N-1:0]   raw_sel;
	logic [MOD_N-1:0]   fold_sel;
	logic [MOD_N-1:0]   mod_next;
	logic [CARD_N-1:0]  card_en_n_next;
	logic [DIGIT_W-1:0] top_mod;
	logic               is_three;
	logic               is_four;
	logic               loader_hit;
	logic               decode_on;
	logic [REG_DW-1:0]  ctrl_reg;
	logic               hit_reg;
	logic [ADDR_W-1:0]  last_addr_reg;
	logic [REG_DW-1:0]  rdata_next;
	cmmd_lines_type     lines_next [CARD_N];

	// Two-stage synchroniser for every pin input; only stage two is read.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= {mem_addr, phase5, loader_protect_sel, stack_count,
				line_timing_enable};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign pin = pin_s2_reg;

	// Presence flags come from the static stack count.
	assign is_three = (pin.stacks == CMMD_THREE_STACK);
	assign is_four  = (pin.stacks == CMMD_FOUR_STACK);

	// Decoder input: with one or two stacks the unused high inputs are held at zero.
	always_comb begin
		case (pin.stacks)
			CMMD_ONE_STACK: begin
				dec_in = {2'b00, pin.addr[MOD_LSB]};
			end
			CMMD_TWO_STACK: begin
				dec_in = {1'b0, pin.addr[MOD_LSB+1:MOD_LSB]};
			end
			default: begin
				dec_in = pin.addr[ADDR_W-1:MOD_LSB];
			end
		endcase
	end

	// One-hot code; pairs 2k and 2k+1 belong to stack k.
	assign raw_sel = oct_decode(1'b1, dec_in);

	// Three stacks: codes 6 and 7 are steered onto modules 0 and 1.
	always_comb begin
		fold_sel = raw_sel;
		if (is_three) begin
			fold_sel[0] = raw_sel[0] | raw_sel[6];
			fold_sel[1] = raw_sel[1] | raw_sel[7];
			fold_sel[7:6] = 2'b00;
		end
	end

	// The loader area sits in the upper module of the last installed stack.
	assign top_mod    = {pin.stacks, 1'b1};
	assign loader_hit = fold_sel[top_mod]
		& (pin.addr[PAGE_W-1:LOADER_LSB] == LOADER_TAG[LOADER_W-1:0]);
	assign decode_on  = ctrl_reg[CTRL_DEC_EN]
		& ~(pin.loader_protect_sel & loader_hit);
	assign mod_next   = decode_on ? fold_sel : '0;

	always_comb begin
		for (int k = 0; k < CARD_N; k++) begin
			card_en_n_next[k] = ~(mod_next[2*k] | mod_next[2*k+1]);
		end
	end

	// Per-card line decoders, each gated by card enable and its timing pulse.
	always_comb begin
		for (int k = 0; k < CARD_N; k++) begin
			logic en;
			logic upper;
			logic xr;
			logic xw;
			en    = ~card_en_n_next[k] & ~pin.phase5;
			upper = mod_next[2*k+1];
			xr    = upper ? pin.timing.x_t2 : pin.timing.x_t1;
			xw    = upper ? pin.timing.x_t1 : pin.timing.x_t2;
			lines_next[k].y_msd_rd = oct_decode(en & pin.timing.y_read,
				pin.addr[Y_MSD_LSB +: DIGIT_W]);
			lines_next[k].y_lsd_rd = oct_decode(en & pin.timing.y_read,
				pin.addr[Y_LSD_LSB +: DIGIT_W]);
			lines_next[k].y_msd_wr = oct_decode(en & pin.timing.y_write,
				pin.addr[Y_MSD_LSB +: DIGIT_W]);
			lines_next[k].y_lsd_wr = oct_decode(en & pin.timing.y_write,
				pin.addr[Y_LSD_LSB +: DIGIT_W]);
			lines_next[k].x_msd_rd = oct_decode(en & xr,
				pin.addr[X_MSD_LSB +: DIGIT_W]);
			lines_next[k].x_lsd_rd = oct_decode(en & xr,
				pin.addr[X_LSD_LSB +: DIGIT_W]);
			lines_next[k].x_msd_wr = oct_decode(en & xw,
				pin.addr[X_MSD_LSB +: DIGIT_W]);
			lines_next[k].x_lsd_wr = oct_decode(en & xw,
				pin.addr[X_LSD_LSB +: DIGIT_W]);
		end
	end

	// Registered outputs toward the stack cards.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			module_select       <= '0;
			card_enable_n       <= '1;
			stack_addr          <= '0;
			three_stack_present <= 1'b0;
			four_stack_present  <= 1'b0;
			for (int k = 0; k < CARD_N; k++) begin
				card_lines[k] <= '0;
			end
		end else begin
			module_select       <= mod_next;
			card_enable_n       <= card_en_n_next;
			stack_addr          <= pin.phase5 ? '0 : pin.addr[PAGE_W-1:0];
			three_stack_present <= is_three;
			four_stack_present  <= is_four;
			for (int k = 0; k < CARD_N; k++) begin
				card_lines[k] <= lines_next[k];
			end
		end
	end

	// Control register: bit 0 enables module decoding.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			ctrl_reg <= reg_wdata & CTRL_RESET;
		end
	end

	// Status capture: last address and whether it fell in the protected area.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hit_reg       <= 1'b0;
			last_addr_reg <= '0;
		end else begin
			hit_reg       <= pin.loader_protect_sel & loader_hit;
			last_addr_reg <= pin.addr;
		end
	end

	always_comb begin
		rdata_next = '0;
		case (reg_addr)
			REG_CTRL: begin
				rdata_next = ctrl_reg;
			end
			REG_STATUS: begin
				rdata_next[STAT_MOD_LSB +: MOD_N] = module_select;
				rdata_next[STAT_HIT_BIT]          = hit_reg;
				rdata_next[STAT_STK_LSB +: 2]     = pin.stacks;
				rdata_next[STAT_STK3_BIT]         = three_stack_present;
				rdata_next[STAT_STK4_BIT]         = four_stack_present;
			end
			REG_ADDR: begin
				rdata_next[ADDR_W-1:0] = last_addr_reg;
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// Read data stand only in the cycle after the read strobe.
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : '0;
		end
	end

endmodule

// >>> src/cmmd_pkg.sv
// Package with constants and types for the core memory module decoder.
package cmmd_pkg;

	localparam int ADDR_W    = 15;
	localparam int MOD_N     = 8;
	localparam int CARD_N    = 4;
	localparam int DIGIT_W   = 3;
	localparam int PAGE_W    = 12;
	localparam int MOD_LSB   = 12;
	localparam int Y_MSD_LSB = 9;
	localparam int Y_LSD_LSB = 6;
	localparam int X_MSD_LSB = 3;
	localparam int X_LSD_LSB = 0;

	// The loader area is the top 64 words: page bits above bit 5 all ones.
	localparam int          LOADER_WORDS = 64;
	localparam int          LOADER_LSB   = $clog2(LOADER_WORDS);
	localparam int          LOADER_W     = PAGE_W - LOADER_LSB;
	localparam logic [5:0]  LOADER_TAG   = 6'h3f;

	localparam int          REG_AW         = 2;
	localparam int          REG_DW         = 16;
	localparam logic [1:0]  REG_CTRL       = 2'h0;
	localparam logic [1:0]  REG_STATUS     = 2'h1;
	localparam logic [1:0]  REG_ADDR       = 2'h2;
	localparam int          CTRL_DEC_EN    = 0;
	localparam logic [15:0] CTRL_RESET     = 16'h0001;
	localparam int          STAT_MOD_LSB   = 0;
	localparam int          STAT_HIT_BIT   = 8;
	localparam int          STAT_STK_LSB   = 9;
	localparam int          STAT_STK3_BIT  = 11;
	localparam int          STAT_STK4_BIT  = 12;

	typedef enum logic [1:0] {
		CMMD_ONE_STACK   = 2'h0,
		CMMD_TWO_STACK   = 2'h1,
		CMMD_THREE_STACK = 2'h2,
		CMMD_FOUR_STACK  = 2'h3
	} cmmd_stacks_type;

	typedef struct packed {
		logic y_read;
		logic y_write;
		logic x_t1;
		logic x_t2;
	} cmmd_timing_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              phase5;
		logic              loader_protect_sel;
		cmmd_stacks_type   stacks;
		cmmd_timing_type   timing;
	} cmmd_pins_type;

	typedef struct packed {
		logic [7:0] y_msd_rd;
		logic [7:0] y_lsd_rd;
		logic [7:0] y_msd_wr;
		logic [7:0] y_lsd_wr;
		logic [7:0] x_msd_rd;
		logic [7:0] x_lsd_rd;
		logic [7:0] x_msd_wr;
		logic [7:0] x_lsd_wr;
	} cmmd_lines_type;

endpackage

// >>> tb/cmmd_card_model.sv
// Model of the stack driver cards that sit behind the decoder.
module cmmd_card_model
	import cmmd_pkg::*;
(
	input  wire logic [CARD_N-1:0] card_enable_n,
	input  wire cmmd_lines_type    card_lines [CARD_N],
	output logic [CARD_N-1:0]      card_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	// A card works only while selected and while some timing line is decoded.
	always_comb begin
		for (int k = 0; k < CARD_N; k++) begin
			card_busy[k] = !card_enable_n[k] && (|card_lines[k]);
		end
	end
endmodule

// >>> tb/cmmd_decoder_bench.sv
// Self-checking bench for the core memory module decoder.
module cmmd_decoder_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cmmd_pkg::*;
	logic            core_clk, rstn, phase5, protect, reg_wr, reg_rd, p3, p4;
	logic [14:0]     mem_addr;
	cmmd_stacks_type stk;
	cmmd_timing_type tim;
	logic [1:0]      reg_addr;
	logic [15:0]     reg_wdata, reg_rdata;
	logic [7:0]      sel;
	logic [3:0]      cen_n, busy;
	logic [11:0]     saddr;
	cmmd_lines_type  ln [CARD_N];
	int              n_mismatch = 0;
	int              n_tests = 0;
	cmmd_decoder uut(.core_clk, .rstn, .mem_addr, .phase5, .loader_protect_sel(protect),
		.stack_count(stk), .line_timing_enable(tim), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .module_select(sel), .card_enable_n(cen_n), .stack_addr(saddr),
		.card_lines(ln), .three_stack_present(p3), .four_stack_present(p4));
	cmmd_card_model u_cards(.card_enable_n(cen_n), .card_lines(ln), .card_busy(busy));
	task automatic check(input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic pins(input logic [14:0] a, input cmmd_stacks_type s, input logic p, pr,
		input cmmd_timing_type t);
		@(posedge core_clk);
		mem_addr <= a;
		stk <= s;
		phase5 <= p;
		protect <= pr;
		tim <= t;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	task automatic rw(input logic w, input logic [1:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge core_clk);
		reg_wr <= 0;
		reg_rd <= 0;
		#1;
		if (!w) check(reg_rdata, d);
	endtask
	task automatic t_fold();
		int e;
		for (int s = 0; s < 4; s++) begin
			for (int c = 0; c < 8; c++) begin
				pins({c[2:0], 12'h000}, cmmd_stacks_type'(s), 0, 0, 4'h0);
				e = s == 0 ? c % 2 : s == 1 ? c % 4 : (s == 2 && c > 5) ? c - 6 : c;
				check(sel, 8'h01 << e);
				check(cen_n, 4'(~(4'h1 << e / 2)));
				check({p3, p4, busy}, {s == 2, s == 3, 4'h0});
			end
		end
	endtask
	task automatic t_protect();
		pins(15'h5fc0, CMMD_THREE_STACK, 0, 1, 4'h8);
		check({sel, cen_n}, 12'h00f);
		pins(15'h5fc0, CMMD_THREE_STACK, 0, 0, 4'h8);
		check(sel, 8'h20);
		pins(15'h5f80, CMMD_THREE_STACK, 0, 1, 4'h8);
		check(sel, 8'h20);
	endtask
	task automatic t_walk();
		pins(15'o05270, CMMD_FOUR_STACK, 0, 0, 4'h8);
		check(saddr, 12'o5270);
		check({ln[0].y_msd_rd, ln[0].y_lsd_rd, busy}, 20'h20041);
		check(ln[1], 0);
		pins(15'o05270, CMMD_FOUR_STACK, 0, 0, 4'h2);
		check({ln[0].x_msd_rd, ln[0].x_lsd_rd, ln[0].x_msd_wr}, 24'h800100);
		pins(15'o15270, CMMD_FOUR_STACK, 0, 0, 4'h2);
		check({ln[0].x_msd_wr, ln[0].x_lsd_wr, ln[0].x_msd_rd}, 24'h800100);
		pins(15'o15270, CMMD_FOUR_STACK, 0, 0, 4'h4);
		check({ln[0].y_msd_wr, ln[0].y_lsd_wr, ln[0].y_msd_rd}, 24'h200400);
		pins(15'o15270, CMMD_FOUR_STACK, 1, 0, 4'h2);
		check({saddr, sel}, 20'h00002);
		check(ln[0], 0);
	endtask
	task automatic t_regs();
		pins(15'o05270, CMMD_FOUR_STACK, 0, 0, 4'h0);
		rw(0, 2'h1, 16'h1601);
		rw(0, 2'h2, 16'h0ab8);
		rw(1, 2'h3, 16'hffff);
		rw(0, 2'h3, 16'h0000);
		rw(0, 2'h0, 16'h0001);
		rw(1, 2'h0, 16'h0000);
		pins(15'o05270, CMMD_FOUR_STACK, 0, 0, 4'h0);
		check({sel, cen_n}, 12'h00f);
		rw(1, 2'h0, 16'h0001);
	endtask
	task automatic end_sim();
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		{rstn, phase5, protect, reg_wr, reg_rd, reg_addr, reg_wdata, mem_addr} = '0;
		stk = CMMD_ONE_STACK;
		tim = 4'h0;
		repeat (16) @(posedge core_clk);
		rstn <= 1;
		t_fold();
		t_protect();
		t_walk();
		t_regs();
		end_sim();
	end
	initial begin
		#1000000;
		n_mismatch++;
		end_sim();
	end
endmodule

// >>> tb/cmmd_decoder_sva.sv
// Checker on the ports of the core memory module decoder.
module cmmd_decoder_sva
	import cmmd_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              phase5,
	input wire cmmd_stacks_type   stack_count,
	input wire logic [MOD_N-1:0]  module_select,
	input wire logic [CARD_N-1:0] card_enable_n,
	input wire logic [PAGE_W-1:0] stack_addr,
	input wire logic              four_stack_present
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [PAGE_W-1:0] low_addr;
	assign low_addr = mem_addr[PAGE_W-1:0];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence settled;
		$past(rstn, 3) && !$past(phase5, 3);
	endsequence
	onehot_sel_a: assert property ($onehot0(module_select))
		else $error("select not one-hot");
	card_pair_a: assert property (card_enable_n == ~{|module_select[7:6],
		|module_select[5:4], |module_select[3:2], |module_select[1:0]}) else $error("card pair");
	fold_one_a: assert property ($past(stack_count, 3) == CMMD_ONE_STACK
		|-> module_select[7:2] == 0) else $error("one stack fold");
	fold_two_a: assert property ($past(stack_count, 3) == CMMD_TWO_STACK
		|-> module_select[7:4] == 0) else $error("two stack fold");
	fold_three_a: assert property ($past(stack_count, 3) == CMMD_THREE_STACK
		|-> module_select[7:6] == 0) else $error("three stack fold");
	addr_fwd_a: assert property (settled |-> stack_addr == $past(low_addr, 3))
		else $error("address not forwarded");
	phase_zero_a: assert property ($past(phase5, 3) |-> stack_addr == 0)
		else $error("address in phase five");
	four_pres_a: assert property ($past(rstn, 3) |-> four_stack_present ==
		($past(stack_count, 3) == CMMD_FOUR_STACK)) else $error("presence");
endmodule
bind cmmd_decoder cmmd_decoder_sva u_sva(
	.core_clk           (core_clk),
	.rstn               (rstn),
	.mem_addr           (mem_addr),
	.phase5             (phase5),
	.stack_count        (stack_count),
	.module_select      (module_select),
	.card_enable_n      (card_enable_n),
	.stack_addr         (stack_addr),
	.four_stack_present (four_stack_present)
);
